//--- include/timer_pkg.sv
package timer_pkg;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h00;
  localparam logic [7:0] ADDR_COUNT = 8'h01;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h02;
  localparam logic [7:0] ADDR_SYS_CTRL = 8'h03;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h04;
  localparam logic [7:0] ADDR_PORT_DATA = 8'h05;
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_EN_BIT = 4;
  localparam int CTRL_MODE_LSB = 6;
  localparam int INT_EN_BIT = 0;
  localparam int INT_FLAG_BIT = 1;
  localparam int INT_SET_BIT = 2;
  localparam int BUZZ_LO_BIT = 0;
  localparam int BUZZ_HI_BIT = 1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_CAPTURE = 2'h3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  localparam int SYNC_STAGES = 2;
  typedef enum logic [2:0] {
    CAP_IDLE = 3'b001,
    CAP_ARMED = 3'b010,
    CAP_MEASURE = 3'b100
  } cap_state_e;
endpackage

//--- src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_r;

  // The first stage is seen by the second stage alone, to keep metastability contained.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      meta_r <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- src/timer_event_counter_buzzer.sv
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter_buzzer (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic tmr_pin_i,
  input wire logic powerdown_i,
  output logic irq_o,
  output logic wake_o,
  output logic port_data_bit_zero_o,
  output logic port_data_bit_zero_oe_o,
  output logic port_data_bit_one_o,
  output logic port_data_bit_one_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic [7:0] preload_r;
  logic int_en_r;
  logic flag_r;
  logic flag_nxt;
  logic [1:0] sys_ctrl_r;
  logic [1:0] port_direction_reg_r;
  logic [1:0] port_data_r;
  logic [6:0] psc_r;
  logic pin_sync;
  logic pin_prev_r;
  logic buzzer_out_r;
  timer_pkg::cap_state_e cap_r;
  timer_pkg::cap_state_e cap_nxt;

  pin_sync u_pin_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .async_i(tmr_pin_i),
    .sync_o(pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
    hit = (a == target);
  endfunction

  wire wr_ctrl = wr_i && hit(addr_i, timer_pkg::ADDR_TIMER_CTRL);
  wire wr_count = wr_i && hit(addr_i, timer_pkg::ADDR_COUNT);
  wire rd_count = rd_i && hit(addr_i, timer_pkg::ADDR_COUNT);
  wire wr_int = wr_i && hit(addr_i, timer_pkg::ADDR_INT_CTRL);
  wire wr_sys = wr_i && hit(addr_i, timer_pkg::ADDR_SYS_CTRL);
  wire wr_dir = wr_i && hit(addr_i, timer_pkg::ADDR_PORT_DIR);
  wire wr_data = wr_i && hit(addr_i, timer_pkg::ADDR_PORT_DATA);

  wire [2:0] psc_sel = ctrl_r[timer_pkg::CTRL_PSC_LSB +: 3];
  wire active_hi = ctrl_r[timer_pkg::CTRL_EDGE_BIT];
  wire enabled = ctrl_r[timer_pkg::CTRL_EN_BIT];
  wire [1:0] mode = ctrl_r[timer_pkg::CTRL_MODE_LSB +: 2];
  wire buzzer_enable_lo = sys_ctrl_r[timer_pkg::BUZZ_LO_BIT];
  wire buzzer_enable_hi = sys_ctrl_r[timer_pkg::BUZZ_HI_BIT];

  // Prescaled tick: divide by 2 to the power of the select field; select 0 ticks every clock.
  // The prescaler runs free, so the first tick after enabling may come early by up to one period.
  function automatic logic psc_tick(input logic [6:0] cnt, input logic [2:0] sel);
    case (sel)
      3'h0: psc_tick = 1'b1;
      3'h1: psc_tick = cnt[0];
      3'h2: psc_tick = &cnt[1:0];
      3'h3: psc_tick = &cnt[2:0];
      3'h4: psc_tick = &cnt[3:0];
      3'h5: psc_tick = &cnt[4:0];
      3'h6: psc_tick = &cnt[5:0];
      default: psc_tick = &cnt[6:0];
    endcase
  endfunction

  wire tick = psc_tick(psc_r, psc_sel);

  wire pin_active = (pin_sync == active_hi);
  wire pin_edge = (pin_sync != pin_prev_r) && pin_active;
  // A count register read or write steals this cycle's count; software accepts a possible lost count.
  wire inhibit = rd_count || wr_count;

  wire adv_timer = (mode == timer_pkg::MODE_TIMER) && tick;
  wire adv_event = (mode == timer_pkg::MODE_EVENT) && pin_edge;
  wire adv_cap = (mode == timer_pkg::MODE_CAPTURE) && (cap_r == timer_pkg::CAP_MEASURE) && pin_active && tick;
  wire advance = enabled && !inhibit && (adv_timer || adv_event || adv_cap);
  wire overflow = advance && (count_r == timer_pkg::COUNT_FULL);
  wire cap_done = (mode == timer_pkg::MODE_CAPTURE) && (cap_r == timer_pkg::CAP_MEASURE) && !pin_active;

  ////////////////////////////////////////////////////////////////////////////
  // Capture arms on enable, waits for the active edge, then counts until the pin falls back to idle.
  always_comb begin
    cap_nxt = cap_r;
    case (cap_r)
      timer_pkg::CAP_IDLE: begin
        if (enabled && mode == timer_pkg::MODE_CAPTURE) begin
          cap_nxt = timer_pkg::CAP_ARMED;
        end
      end
      timer_pkg::CAP_ARMED: begin
        if (!enabled || mode != timer_pkg::MODE_CAPTURE) begin
          cap_nxt = timer_pkg::CAP_IDLE;
        end else if (pin_edge) begin
          cap_nxt = timer_pkg::CAP_MEASURE;
        end
      end
      timer_pkg::CAP_MEASURE: begin
        if (!enabled || cap_done) begin
          cap_nxt = timer_pkg::CAP_IDLE;
        end
      end
      default: cap_nxt = timer_pkg::CAP_IDLE;
    endcase
  end

  always_comb begin
    ctrl_nxt = wr_ctrl ? wdata_i : ctrl_r;
    if (cap_done) begin
      ctrl_nxt[timer_pkg::CTRL_EN_BIT] = 1'b0;
    end
  end

  always_comb begin
    count_nxt = count_r;
    if (wr_count && !enabled) begin
      count_nxt = wdata_i;
    end else if (overflow) begin
      count_nxt = preload_r;
    end else if (advance) begin
      count_nxt = count_r + 8'h01;
    end
  end

  // A new overflow beats a simultaneous write-one clear so no event is lost.
  always_comb begin
    flag_nxt = flag_r;
    if (wr_int && wdata_i[timer_pkg::INT_FLAG_BIT]) begin
      flag_nxt = 1'b0;
    end
    if (wr_int && wdata_i[timer_pkg::INT_SET_BIT]) begin
      flag_nxt = 1'b1;
    end
    if (overflow) begin
      flag_nxt = 1'b1;
    end
  end

  // The interrupt follows the enable as written, so clearing the enable leaves no stray pulse.
  wire int_en_nxt = wr_int ? wdata_i[timer_pkg::INT_EN_BIT] : int_en_r;

  wire buzz_next = overflow ? ~buzzer_out_r : buzzer_out_r;
  // Pin zero's data bit switches the buzzer pair; pin one's data bit plays no part while buzzing.
  wire buzz_on = port_data_r[0];
  wire pin_zero_val = buzzer_enable_lo ? (buzz_on & buzz_next) : port_data_r[0];
  wire pin_one_val = buzzer_enable_hi ? (buzz_on & ~buzz_next) : port_data_r[1];
  // A direction bit of one makes the pin an input, so the drive enable is its inverse.
  wire pin_zero_drive = ~port_direction_reg_r[0];
  wire pin_one_drive = ~port_direction_reg_r[1];

  function automatic logic [7:0] read_select(
    input logic [7:0] a,
    input logic [7:0] ctrl,
    input logic [7:0] count,
    input logic [7:0] int_ctrl,
    input logic [7:0] sys_ctrl,
    input logic [7:0] dir,
    input logic [7:0] data
  );
    if (hit(a, timer_pkg::ADDR_TIMER_CTRL)) begin
      read_select = ctrl;
    end else if (hit(a, timer_pkg::ADDR_COUNT)) begin
      read_select = count;
    end else if (hit(a, timer_pkg::ADDR_INT_CTRL)) begin
      read_select = int_ctrl;
    end else if (hit(a, timer_pkg::ADDR_SYS_CTRL)) begin
      read_select = sys_ctrl;
    end else if (hit(a, timer_pkg::ADDR_PORT_DIR)) begin
      read_select = dir;
    end else if (hit(a, timer_pkg::ADDR_PORT_DATA)) begin
      read_select = data;
    end else begin
      // Unmapped addresses read as zero.
      read_select = 8'h00;
    end
  endfunction

  wire [7:0] rd_mux = read_select(addr_i, ctrl_r, count_r, {6'h00, flag_r, int_en_r}, {6'h00, sys_ctrl_r},
    {6'h00, port_direction_reg_r}, {6'h00, port_data_r});

  ////////////////////////////////////////////////////////////////////////////
  // Count and preload are data, deliberately left without reset.
  always_ff @(posedge mclk_i) begin
    count_r <= count_nxt;
  end

  always_ff @(posedge mclk_i) begin
    if (wr_count) begin
      preload_r <= wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl_r <= timer_pkg::CTRL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cap_r <= timer_pkg::CAP_IDLE;
    end else begin
      cap_r <= cap_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      psc_r <= 7'h00;
      pin_prev_r <= 1'b0;
    end else begin
      psc_r <= psc_r + 7'h01;
      pin_prev_r <= pin_sync;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      int_en_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      int_en_r <= int_en_nxt;
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sys_ctrl_r <= 2'h0;
    end else if (wr_sys) begin
      sys_ctrl_r <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      port_direction_reg_r <= timer_pkg::PORT_DIR_RESET;
    end else if (wr_dir) begin
      port_direction_reg_r <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      port_data_r <= 2'h0;
    end else if (wr_data) begin
      port_data_r <= wdata_i[1:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      buzzer_out_r <= 1'b0;
    end else begin
      buzzer_out_r <= buzz_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 8'h00;
      irq_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_mux : 8'h00;
      irq_o <= flag_nxt && int_en_nxt;
      wake_o <= overflow && powerdown_i && !flag_r;
    end
  end

  // Each pin's value and drive enable change on the same edge, so the load never sees a half-updated pin.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      port_data_bit_zero_o <= 1'b0;
      port_data_bit_zero_oe_o <= 1'b0;
    end else begin
      port_data_bit_zero_o <= pin_zero_val;
      port_data_bit_zero_oe_o <= pin_zero_drive;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      port_data_bit_one_o <= 1'b0;
      port_data_bit_one_oe_o <= 1'b0;
    end else begin
      port_data_bit_one_o <= pin_one_val;
      port_data_bit_one_oe_o <= pin_one_drive;
    end
  end
endmodule
`default_nettype wire

//--- test/pin_source.sv
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic mclk_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic tmr_pin_o,
  output int toggles_o
);
  initial tmr_pin_o = 1'b0;
  initial toggles_o = 0;
  // Each level is held two clocks or more, or the synchroniser may drop an edge.
  task automatic pulse(input int w);
    repeat (3) @(posedge mclk_i);
    tmr_pin_o <= 1'b1;
    repeat (w) @(posedge mclk_i);
    tmr_pin_o <= 1'b0;
  endtask
  logic pin_seen_r;
  initial pin_seen_r = 1'b0;
  // Buzzer load: counts level changes of the driven pin; unknown levels never count.
  always @(posedge mclk_i) begin
    pin_seen_r <= pin_i;
    if (pin_oe_i && ((pin_i ^ pin_seen_r) === 1'b1)) toggles_o <= toggles_o + 1;
  end
endmodule
`default_nettype wire

//--- test/tecb_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tecb_sva (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic powerdown_i,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic port_data_bit_zero_o,
  input wire logic port_data_bit_zero_oe_o,
  input wire logic port_data_bit_one_o,
  input wire logic port_data_bit_one_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadows of the written control bits; the pin outputs lag them by one edge, irq_o follows ien_r on the same edge.
  logic ien_r, d0_r, bzl_r, bzh_r;
  logic [1:0] dir_r;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      {ien_r, d0_r, bzl_r, bzh_r, dir_r} <= 6'h03;
    end else if (wr_i) begin
      if (addr_i == 8'h02) ien_r <= wdata_i[0];
      if (addr_i == 8'h05) d0_r <= wdata_i[0];
      if (addr_i == 8'h03) {bzh_r, bzl_r} <= wdata_i[1:0];
      if (addr_i == 8'h04) dir_r <= wdata_i[1:0];
    end
  end
  sequence s_pair_on;
    bzl_r && bzh_r && d0_r && dir_r == 2'h0;
  endsequence
  a_irq_masked: assert property (irq_o |-> ien_r || $past(ien_r)) else $error("irq without enable");
  a_irq_hold: assert property (irq_o && !wr_i && !$past(wr_i) |=> irq_o) else $error("irq lost");
  a_wake_pulse: assert property (wake_o |=> !wake_o) else $error("wake too long");
  a_wake_cause: assert property (wake_o |-> $past(powerdown_i)) else $error("wake while awake");
  a_oe_dir: assert property (
    port_data_bit_zero_oe_o == !$past(dir_r[0]) && port_data_bit_one_oe_o == !$past(dir_r[1]))
    else $error("pin drive does not follow direction");
  a_buz_gate: assert property (
    !$past(d0_r) |-> !port_data_bit_zero_o && !($past(bzh_r) && port_data_bit_one_o)) else $error("buzzer not gated");
  a_buz_compl: assert property (
    s_pair_on ##1 s_pair_on |-> port_data_bit_one_o != port_data_bit_zero_o) else $error("pair not inverse");
  a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
endmodule
bind timer_event_counter_buzzer tecb_sva chk_u (
  .mclk_i(mclk_i),
  .rst_n_i(rst_n_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .powerdown_i(powerdown_i),
  .irq_o(irq_o),
  .wake_o(wake_o),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .rdata_o(rdata_o),
  .port_data_bit_zero_o(port_data_bit_zero_o),
  .port_data_bit_zero_oe_o(port_data_bit_zero_oe_o),
  .port_data_bit_one_o(port_data_bit_one_o),
  .port_data_bit_one_oe_o(port_data_bit_one_oe_o)
);
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, powerdown_i = 1'b0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o, v, u;
  logic tmr_pin_i, irq_o, wake_o, port_data_bit_zero_o, port_data_bit_zero_oe_o;
  logic port_data_bit_one_o, port_data_bit_one_oe_o;
  int err_count = 0, cmp_count = 0, seed = 8639, cyc = 0, wakes = 0, toggles, n, p, t0;
  always #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) cyc <= cyc + 1;
  always @(posedge mclk_i) if (wake_o === 1'b1) wakes <= wakes + 1;
  timer_event_counter_buzzer dut_u (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr_i),
    .wdata_i(wdata_i),
    .wr_i(wr_i),
    .rd_i(rd_i),
    .rdata_o(rdata_o),
    .tmr_pin_i(tmr_pin_i),
    .powerdown_i(powerdown_i),
    .irq_o(irq_o),
    .wake_o(wake_o),
    .port_data_bit_zero_o(port_data_bit_zero_o),
    .port_data_bit_zero_oe_o(port_data_bit_zero_oe_o),
    .port_data_bit_one_o(port_data_bit_one_o),
    .port_data_bit_one_oe_o(port_data_bit_one_oe_o)
  );
  pin_source src_u (.mclk_i(mclk_i), .pin_i(port_data_bit_zero_o), .pin_oe_i(port_data_bit_zero_oe_o),
    .tmr_pin_o(tmr_pin_i), .toggles_o(toggles));
  task automatic chk(input logic [7:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register access; read data is taken in the cycle after the strobe.
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge mclk_i);
    wr_i <= w;
    rd_i <= !w;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    {wr_i, rd_i} <= 2'b00;
    @(negedge mclk_i);
    v = rdata_o;
  endtask
  task automatic wirq;
    n = 2;
    repeat (2) @(negedge mclk_i);
    while (irq_o !== 1'b1 && n < 600) begin
      @(negedge mclk_i);
      n++;
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    bus(0, 8'h00, 8'h00);
    chk(v, timer_pkg::CTRL_RESET);
    bus(0, 8'h07, 8'h00);
    chk(v, 8'h00);
    p = $random(seed) & 8'h3F;
    bus(1, 8'h01, 8'(p));
    bus(1, 8'h02, 8'h01);
    bus(1, 8'h00, 8'h90);
    wirq();
    chk(8'(n >= 254 - p && n <= 262 - p), 8'h01);
    // The second lap reads the counter, which must cost exactly one count.
    for (int k = 0; k < 2; k++) begin
      t0 = cyc;
      bus(1, 8'h02, 8'h03);
      if (k == 1) bus(0, 8'h01, 8'h00);
      wirq();
      chk(8'(cyc - t0), 8'(256 + k - p));
    end
    bus(1, 8'h00, 8'h80);
    bus(1, 8'h02, 8'h04);
    repeat (3) @(negedge mclk_i);
    chk({7'h00, irq_o}, 8'h00);
    bus(1, 8'h02, 8'h01);
    repeat (3) @(negedge mclk_i);
    chk({7'h00, irq_o}, 8'h01);
    bus(0, 8'h01, 8'h00);
    u = v;
    repeat (9) @(posedge mclk_i);
    bus(0, 8'h01, 8'h00);
    chk(v, u);
    $display("timer test done");
    bus(1, 8'h02, 8'h02);
    bus(1, 8'h01, 8'hFE);
    @(posedge mclk_i) powerdown_i <= 1'b1;
    bus(1, 8'h00, 8'h58);
    for (int k = 0; k < 4; k++) begin
      src_u.pulse(2 + k);
      repeat (6) @(posedge mclk_i);
      bus(0, 8'h02, 8'h00);
      chk(v, 8'(k > 0 ? 2 : 0));
    end
    chk(8'(wakes), 8'h01);
    // Falling-edge events: only the trailing edge of one pulse may count.
    bus(1, 8'h00, 8'h50);
    src_u.pulse(3);
    repeat (6) @(posedge mclk_i);
    bus(0, 8'h01, 8'h00);
    chk(v, 8'hFF);
    @(posedge mclk_i) powerdown_i <= 1'b0;
    $display("event test done");
    bus(1, 8'h00, 8'h00);
    bus(1, 8'h01, 8'h00);
    bus(1, 8'h00, 8'hD8);
    p = 20 + ($random(seed) & 15);
    src_u.pulse(p);
    repeat (6) @(posedge mclk_i);
    bus(0, 8'h00, 8'h00);
    chk(v, 8'hC8);
    bus(0, 8'h01, 8'h00);
    u = v;
    chk(8'(v >= p - 2 && v <= p + 2), 8'h01);
    src_u.pulse(4);
    repeat (6) @(posedge mclk_i);
    bus(0, 8'h01, 8'h00);
    chk(v, u);
    $display("capture test done");
    bus(1, 8'h04, 8'h00);
    bus(1, 8'h05, 8'h01);
    bus(1, 8'h03, 8'h03);
    bus(1, 8'h01, 8'hF0);
    bus(1, 8'h00, 8'h90);
    n = toggles;
    repeat (160) @(posedge mclk_i);
    chk(8'(toggles - n >= 9 && toggles - n <= 11), 8'h01);
    bus(1, 8'h05, 8'h00);
    repeat (3) @(negedge mclk_i);
    chk({6'h00, port_data_bit_one_o, port_data_bit_zero_o}, 8'h00);
    $display("buzzer test done");
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    err_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
